/* hw/pssc_strap_two.sv */
// Second software-strap control register with its AHB-Lite slave and the link behaviour it steers.
// Assumes one 250 MHz clock, synchronous link-side inputs and one tx_en sample per hclk cycle.
`timescale 1ns/100ps
`default_nettype none
`include "pssc_map.svh"

// Behaviour
// - Setting config-done makes a one-cycle internal reset pulse and copies the straps into the active set.
// - Bit 15 enables forced-100 far-end link drop and resets to 0.
// - With that mode on and speed forced to 100, losing local link disables the transmitter.
// - Bit 14 set selects fiber operation and resets to 0.
// - Bit 6 set selects fast parallel-detect link-up, clear selects the normal one, reset 0.
// - Either crossover mode in register one sets the fast parallel-detect bit automatically.
// - With bit 5 set, auto-negotiation or forced 100 against a forced-100 partner always gives full duplex.
// - With bit 5 clear, duplex follows the standard resolution.
// - With bit 4 set, the link LED lights only on a 100TX full-duplex link.
// - With bit 4 clear, the link LED lights on any established link.
// - With bit 3 set, MII outputs are isolated on a 100TX half-duplex link.
// - With bit 3 clear, MII outputs are driven normally.
// - Bit 2, reset 1, enables idle receive symbol error detection.
// - With bit 1 clear, tx_en falling on an odd nibble is extended one cycle with tx_er asserted.
// - Bit 0 selects RMII receive data referenced to rx_clk (1) or the crystal input clock (0).
module pssc_strap_two
    import pssc_pkg::*;
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Link status from the PHY core.
    input  wire logic        link_up,
    input  wire logic        link_speed_100,
    input  wire logic        std_full_duplex,
    input  wire logic        forced_100,
    input  wire logic        autoneg_enabled,
    input  wire logic        partner_forced_100,
    // MAC transmit path.
    input  wire logic        tx_en_in,
    input  wire logic        tx_er_in,
    output logic             tx_en_out,
    output logic             tx_er_out,
    // Strap effects.
    output logic             strap_reset_pulse,
    output logic             tx_disable,
    output logic             fiber_mode,
    output logic             fast_pd_link_up,
    output logic             full_duplex,
    output logic             link_led,
    output logic             mii_out_en,
    output logic             idle_symbol_error_detect,
    output logic             rmii_rx_clk_ref
);

    pssc_reg_t      one_ff;
    pssc_reg_t      two_ff;
    pssc_reg_t      act_ff;
    pssc_reg_t      two_read;
    logic           pulse_ff;
    logic           wr_pend_ff;
    logic [7:0]     idx_ff;
    logic           hit_ok;
    logic [7:0]     idx_now;
    logic           xover_on;
    logic           wr_one;
    logic           wr_two;
    logic           done_rise;
    logic           fd_now;
    logic           extend_now;
    logic [31:0]    nxt_rdata;
    logic [31:0]    hrdata_ff;
    logic           tx_en_ff;
    logic           tx_er_ff;
    logic           tx_dis_ff;
    logic           fiber_ff;
    logic           fastpd_ff;
    logic           fd_ff;
    logic           led_ff;
    logic           mii_en_ff;
    logic           idle_ff;
    logic           rmii_ff;
    logic           par_ff;
    pssc_tx_state_t tx_state_ff;
    pssc_tx_state_t nxt_tx_state;

    // The slave never inserts wait states and never errors, so reads return in the data phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    // Word index of the current address phase; anything outside the low kilobyte is unmapped.
    assign idx_now = haddr[`PSSC_ADDR_IDX_HI:`PSSC_ADDR_IDX_LO];
    assign hit_ok  = hsel & hready & htrans[1];

    // Reserved field always reads its fixed value, and bit 6 also reflects the crossover modes.
    assign xover_on = one_ff[`PSSC_B_QUICK] | one_ff[`PSSC_B_ROBUST];
    always_comb begin
        two_read = two_ff;
        two_read[`PSSC_B_RSV_HI:`PSSC_B_RSV_LO] = `PSSC_RSV_VAL;
        two_read[`PSSC_B_FASTPD] = two_ff[`PSSC_B_FASTPD] | xover_on;
    end

    // Read data is captured at the end of the address phase from the register state of that moment.
    always_comb begin
        nxt_rdata = `PSSC_ZERO32;
        if (haddr[`PSSC_ADDR_TOP_HI:`PSSC_ADDR_TOP_LO] == `PSSC_ADDR_TOP_ZERO) begin
            case (idx_now)
                `PSSC_IDX_ONE: nxt_rdata = {`PSSC_ZERO16, one_ff};
                `PSSC_IDX_TWO: nxt_rdata = {`PSSC_ZERO16, two_read};
                `PSSC_IDX_ACT: nxt_rdata = {`PSSC_ZERO16, act_ff};
                default:       nxt_rdata = `PSSC_ZERO32;
            endcase
        end
    end

    // Address phase capture; hsize is accepted as given since only whole words are written.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            idx_ff     <= 8'h00;
            hrdata_ff  <= `PSSC_ZERO32;
        end else begin
            if (hready) begin
                wr_pend_ff <= hit_ok & hwrite
                              & (haddr[`PSSC_ADDR_TOP_HI:`PSSC_ADDR_TOP_LO] == `PSSC_ADDR_TOP_ZERO);
                idx_ff     <= idx_now;
            end
            if (hit_ok && !hwrite) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    assign wr_one = wr_pend_ff & (idx_ff == `PSSC_IDX_ONE);
    assign wr_two = wr_pend_ff & (idx_ff == `PSSC_IDX_TWO);

    // Register one keeps only config-done and the two crossover mode bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            one_ff <= `PSSC_ONE_RST;
        end else if (wr_one) begin
            one_ff <= hwdata[15:0] & `PSSC_ONE_WMASK;
        end
    end

    // Register two; reserved bits are not writable and the crossover modes force bit 6 on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            two_ff <= `PSSC_TWO_RST;
        end else begin
            if (wr_two) begin
                two_ff <= (hwdata[15:0] & `PSSC_TWO_WMASK) | (two_ff & ~`PSSC_TWO_WMASK);
            end
            if (xover_on) begin
                two_ff[`PSSC_B_FASTPD] <= 1'b1;
            end
        end
    end

    // Config-done rising makes the internal reset pulse; the straps are copied while it stands.
    assign done_rise = wr_one & hwdata[`PSSC_B_DONE] & ~one_ff[`PSSC_B_DONE];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= done_rise;
        end
    end

    // Active straps change only at the pulse, so rewriting register two later has no effect until the next one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff <= `PSSC_TWO_RST;
        end else if (pulse_ff) begin
            act_ff <= two_read;
        end
    end

    assign strap_reset_pulse = pulse_ff;

    // Duplex resolution; the extended ability overrides the standard result only against a forced partner.
    always_comb begin
        fd_now = std_full_duplex;
        if (act_ff[`PSSC_B_EXTFD] && (autoneg_enabled || forced_100) && partner_forced_100) begin
            fd_now = 1'b1;
        end
    end

    // Strap effects are registered so that the link side sees clean levels.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_dis_ff <= 1'b0;
            fiber_ff  <= 1'b0;
            fastpd_ff <= 1'b0;
            fd_ff     <= 1'b0;
            led_ff    <= 1'b0;
            mii_en_ff <= 1'b1;
            idle_ff   <= 1'b1;
            rmii_ff   <= 1'b0;
        end else begin
            tx_dis_ff <= act_ff[`PSSC_B_FAR] & forced_100 & ~link_up;
            fiber_ff  <= act_ff[`PSSC_B_FIBER];
            fastpd_ff <= act_ff[`PSSC_B_FASTPD];
            fd_ff     <= fd_now;
            if (act_ff[`PSSC_B_LED]) begin
                led_ff <= link_up & link_speed_100 & fd_now;
            end else begin
                led_ff <= link_up;
            end
            if (act_ff[`PSSC_B_ISO]) begin
                mii_en_ff <= ~(link_up & link_speed_100 & ~fd_now);
            end else begin
                mii_en_ff <= 1'b1;
            end
            idle_ff   <= act_ff[`PSSC_B_IDLE];
            rmii_ff   <= act_ff[`PSSC_B_RMII];
        end
    end

    assign tx_disable               = tx_dis_ff;
    assign fiber_mode               = fiber_ff;
    assign fast_pd_link_up          = fastpd_ff;
    assign full_duplex              = fd_ff;
    assign link_led                 = led_ff;
    assign mii_out_en               = mii_en_ff;
    assign idle_symbol_error_detect = idle_ff;
    assign rmii_rx_clk_ref          = rmii_ff;

    // A frame that ends after an odd number of nibbles gets one padding cycle flagged as an error.
    assign extend_now = (tx_state_ff == PSSC_TX_SEND) & ~tx_en_in & par_ff & ~act_ff[`PSSC_B_ODD];
    always_comb begin
        case (tx_state_ff)
            PSSC_TX_IDLE:   nxt_tx_state = tx_en_in ? PSSC_TX_SEND : PSSC_TX_IDLE;
            PSSC_TX_SEND: begin
                if (tx_en_in) begin
                    nxt_tx_state = PSSC_TX_SEND;
                end else if (extend_now) begin
                    nxt_tx_state = PSSC_TX_EXTEND;
                end else begin
                    nxt_tx_state = PSSC_TX_IDLE;
                end
            end
            PSSC_TX_EXTEND: nxt_tx_state = PSSC_TX_IDLE;
            default:        nxt_tx_state = PSSC_TX_IDLE;
        endcase
    end

    // Nibble parity counts the cycles of the current frame; it restarts at each frame start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_ff <= PSSC_TX_IDLE;
            par_ff      <= 1'b0;
            tx_en_ff    <= 1'b0;
            tx_er_ff    <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            par_ff      <= tx_en_in ? ((tx_state_ff == PSSC_TX_SEND) ? ~par_ff : 1'b1) : 1'b0;
            tx_en_ff    <= tx_en_in | extend_now;
            tx_er_ff    <= tx_er_in | extend_now;
        end
    end

    assign tx_en_out = tx_en_ff;
    assign tx_er_out = tx_er_ff;

    // Checks on the strap path and the link effects.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_done_write;
        done_rise;
    endsequence

    sequence s_one_pulse;
        pulse_ff ##1 !pulse_ff;
    endsequence

    property p_done_pulse;
        s_done_write |=> s_one_pulse;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("config-done did not give one pulse");

    property p_latch;
        pulse_ff |=> (act_ff == $past(two_read));
    endproperty
    a_latch: assert property (p_latch) else $error("straps not latched at the pulse");

    property p_far_drop;
        (act_ff[`PSSC_B_FAR] && forced_100 && !link_up) |=> tx_disable;
    endproperty
    a_far_drop: assert property (p_far_drop) else $error("transmitter not disabled on link loss");

    property p_fiber;
        ##1 (fiber_mode == $past(act_ff[`PSSC_B_FIBER]));
    endproperty
    a_fiber: assert property (p_fiber) else $error("fiber mode does not follow the active strap");

    property p_xover;
        xover_on |-> two_read[`PSSC_B_FASTPD] ##1 two_ff[`PSSC_B_FASTPD];
    endproperty
    a_xover: assert property (p_xover) else $error("crossover mode did not set fast link-up");

    property p_ext_fd;
        (act_ff[`PSSC_B_EXTFD] && partner_forced_100 && (autoneg_enabled || forced_100)) |=> full_duplex;
    endproperty
    a_ext_fd: assert property (p_ext_fd) else $error("extended full duplex not forced");

    property p_led;
        (act_ff[`PSSC_B_LED] && link_up && !link_speed_100) |=> !link_led;
    endproperty
    a_led: assert property (p_led) else $error("link led lit on a 10 link in enhanced mode");

    property p_iso;
        (act_ff[`PSSC_B_ISO] && link_up && link_speed_100 && !fd_now) |=> !mii_out_en;
    endproperty
    a_iso: assert property (p_iso) else $error("mii outputs not isolated on half duplex");

    property p_rsv;
        (two_read[`PSSC_B_RSV_HI:`PSSC_B_RSV_LO] == `PSSC_RSV_VAL)
        && (act_ff[`PSSC_B_RSV_HI:`PSSC_B_RSV_LO] == `PSSC_RSV_VAL);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved field changed");

    sequence s_odd_end;
        (tx_state_ff == PSSC_TX_SEND) && par_ff && !tx_en_in && !act_ff[`PSSC_B_ODD];
    endsequence

    property p_odd;
        s_odd_end |=> (tx_en_out && tx_er_out) ##1 (tx_state_ff == PSSC_TX_IDLE);
    endproperty
    a_odd: assert property (p_odd) else $error("odd nibble end not extended");

endmodule
`default_nettype wire

/* hw/pssc_map.svh */
// Register map and bit positions of the second software-strap control block.
// Assumes a 32-bit AHB-Lite bus; each register sits in one aligned word at four times its index.
`ifndef PSSC_MAP_SVH
`define PSSC_MAP_SVH

`define PSSC_IDX_ONE      8'h09
`define PSSC_IDX_TWO      8'h0a
`define PSSC_IDX_ACT      8'h0c
`define PSSC_ADDR_IDX_HI  9
`define PSSC_ADDR_IDX_LO  2
`define PSSC_ADDR_TOP_HI  31
`define PSSC_ADDR_TOP_LO  10
`define PSSC_ADDR_TOP_ZERO 22'h000000
`define PSSC_B_DONE       15
`define PSSC_B_QUICK      6
`define PSSC_B_ROBUST     5
`define PSSC_B_FAR        15
`define PSSC_B_FIBER      14
`define PSSC_B_RSV_HI     13
`define PSSC_B_RSV_LO     7
`define PSSC_B_FASTPD     6
`define PSSC_B_EXTFD      5
`define PSSC_B_LED        4
`define PSSC_B_ISO        3
`define PSSC_B_IDLE       2
`define PSSC_B_ODD        1
`define PSSC_B_RMII       0
`define PSSC_RSV_VAL      7'h02
`define PSSC_TWO_RST      16'h0104
`define PSSC_ONE_RST      16'h0000
`define PSSC_TWO_WMASK    16'hc07f
`define PSSC_ONE_WMASK    16'h8060
`define PSSC_ZERO16       16'h0000
`define PSSC_ZERO32       32'h0000_0000

`endif

/* hw/pssc_pkg.sv */
// Types shared by the strap control block.
// Assumes the map header supplies every numeric constant.
package pssc_pkg;

    // Transmit-enable tracker for odd-nibble end detection.
    typedef enum logic [1:0] {
        PSSC_TX_IDLE,
        PSSC_TX_SEND,
        PSSC_TX_EXTEND
    } pssc_tx_state_t;

    typedef logic [15:0] pssc_reg_t;

endpackage

/* tb/tb_top.sv */
// Self-checking bench for the second software-strap control block.
// Assumes the design answers every AHB-Lite transfer with hreadyout high and OKAY.
`timescale 1ns/100ps
`default_nettype none
`include "pssc_map.svh"

module tb_top;
    localparam logic [31:0] A_ONE = {22'h0, `PSSC_IDX_ONE, 2'b00};
    localparam logic [31:0] A_TWO = {22'h0, `PSSC_IDX_TWO, 2'b00};
    localparam logic [31:0] A_ACT = {22'h0, `PSSC_IDX_ACT, 2'b00};
    localparam logic [15:0] RSV   = {2'b00, `PSSC_RSV_VAL, 7'h00};

    logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        link_up, link_speed_100, std_full_duplex, forced_100, autoneg_enabled, partner_forced_100;
    logic        tx_en_in, tx_er_in, tx_en_out, tx_er_out, strap_reset_pulse, tx_disable, fiber_mode;
    logic        fast_pd_link_up, full_duplex, link_led, mii_out_en, idle_symbol_error_detect, rmii_rx_clk_ref;
    int          error_cnt, num_checks, pulse_cnt, en_cnt, er_cnt;

    pssc_strap_two dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .link_up(link_up), .link_speed_100(link_speed_100),
        .std_full_duplex(std_full_duplex), .forced_100(forced_100), .autoneg_enabled(autoneg_enabled),
        .partner_forced_100(partner_forced_100), .tx_en_in(tx_en_in), .tx_er_in(tx_er_in),
        .tx_en_out(tx_en_out), .tx_er_out(tx_er_out), .strap_reset_pulse(strap_reset_pulse),
        .tx_disable(tx_disable), .fiber_mode(fiber_mode), .fast_pd_link_up(fast_pd_link_up),
        .full_duplex(full_duplex), .link_led(link_led), .mii_out_en(mii_out_en),
        .idle_symbol_error_detect(idle_symbol_error_detect), .rmii_rx_clk_ref(rmii_rx_clk_ref)
    );

    // Clock of 4 ns period.
    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    // Count pulse and transmit cycles so that one-cycle outputs are never missed.
    always @(posedge hclk) begin
        if (strap_reset_pulse === 1'b1) pulse_cnt++;
        if (tx_en_out === 1'b1) en_cnt++;
        if (tx_er_out === 1'b1) er_cnt++;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // Bounded wait for hready at a rising edge.
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 50) chk_word(32'h1, 32'h0);
    endtask

    task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        wait_rdy();
        q = hrdata;
        chk_bit(hresp, 1'b0);
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        chk_word(q, exp);
    endtask

    // Load register two, then raise config-done from 0 to 1 and expect exactly one pulse.
    task automatic apply(input logic [15:0] v, input logic [15:0] one);
        int p;
        bus_wr(A_TWO, {16'h0, v});
        bus_wr(A_ONE, {16'h0, one});
        p = pulse_cnt;
        bus_wr(A_ONE, {16'h0, one | 16'h8000});
        repeat (4) @(posedge hclk);
        chk_word(pulse_cnt - p, 1);
    endtask

    task automatic t_reset_values();
        rd_chk(A_TWO, {16'h0, `PSSC_TWO_RST});
        rd_chk(A_ONE, 32'h0);
        rd_chk(A_ACT, {16'h0, `PSSC_TWO_RST});
        chk_bit(idle_symbol_error_detect, 1'b1);
        chk_bit(fiber_mode, 1'b0);
        chk_bit(tx_disable, 1'b0);
    endtask

    // All ones: reserved bits must keep their value; straps act only after config-done.
    task automatic t_write_apply();
        bus_wr(A_TWO, 32'hffff_ffff);
        rd_chk(A_TWO, {16'h0, 16'hc07f | RSV});
        rd_chk(A_ACT, {16'h0, `PSSC_TWO_RST});
        chk_bit(fiber_mode, 1'b0);
        apply(16'hc07b, 16'h0000);
        rd_chk(A_ACT, {16'h0, 16'hc07b | RSV});
        chk_bit(fiber_mode, 1'b1);
        chk_bit(fast_pd_link_up, 1'b1);
        chk_bit(idle_symbol_error_detect, 1'b0);
        chk_bit(rmii_rx_clk_ref, 1'b1);
        rd_chk(32'h0000_0100, 32'h0);
        bus_wr(32'h0000_0100, 32'h0000_ffff);
        // Register two still holds what apply loaded; the unmapped write must not reach it.
        rd_chk(A_TWO, {16'h0, 16'hc07b | RSV});
    endtask

    // Far-end drop only acts with speed forced to 100.
    task automatic t_far_drop();
        apply(16'h8000, 16'h0000);
        link_up <= 1'b0;
        forced_100 <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_bit(tx_disable, 1'b1);
        link_up <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_bit(tx_disable, 1'b0);
        link_up <= 1'b0;
        forced_100 <= 1'b0;
        repeat (3) @(posedge hclk);
        chk_bit(tx_disable, 1'b0);
        apply(16'h0000, 16'h0000);
        forced_100 <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_bit(tx_disable, 1'b0);
    endtask

    // Half-duplex standard result against a forced-100 partner, under each strap mix.
    task automatic t_link(input logic [15:0] v, input logic fd, input logic led, input logic mii);
        apply(v, 16'h0000);
        link_up <= 1'b1;
        link_speed_100 <= 1'b1;
        std_full_duplex <= 1'b0;
        autoneg_enabled <= 1'b1;
        partner_forced_100 <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_bit(full_duplex, fd);
        chk_bit(link_led, led);
        chk_bit(mii_out_en, mii);
    endtask

    task automatic t_crossover(input logic [15:0] one);
        apply(16'h0000, one);
        rd_chk(A_TWO, {16'h0, 16'h0040 | RSV});
        chk_bit(fast_pd_link_up, 1'b1);
        // Leave crossover first, or it sets bit 6 again while register two is rewritten.
        bus_wr(A_ONE, 32'h0);
        apply(16'h0000, 16'h0000);
        chk_bit(fast_pd_link_up, 1'b0);
    endtask

    // Send a frame of n nibbles and count the delayed enable and error cycles.
    task automatic t_frame(input int n, input int exp_en, input int exp_er);
        int e0, r0;
        e0 = en_cnt;
        r0 = er_cnt;
        tx_en_in <= 1'b1;
        repeat (n) @(posedge hclk);
        tx_en_in <= 1'b0;
        repeat (5) @(posedge hclk);
        chk_word(en_cnt - e0, exp_en);
        chk_word(er_cnt - r0, exp_er);
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        {error_cnt, num_checks, pulse_cnt, en_cnt, er_cnt} = '0;
        {hsel, hwrite, htrans, haddr, hwdata, tx_en_in, tx_er_in} = '0;
        hsize = 3'h2;
        {link_up, link_speed_100, std_full_duplex, forced_100, autoneg_enabled, partner_forced_100} = '0;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values();
        t_write_apply();
        t_far_drop();
        t_link(16'h0018, 1'b0, 1'b0, 1'b0);
        t_link(16'h0038, 1'b1, 1'b1, 1'b1);
        t_link(16'h0000, 1'b0, 1'b1, 1'b1);
        t_link(16'h0010, 1'b0, 1'b0, 1'b1);
        // Enhanced LED stays dark on a 10 Mb link as well.
        link_speed_100 <= 1'b0;
        repeat (3) @(posedge hclk);
        chk_bit(link_led, 1'b0);
        t_link(16'h0008, 1'b0, 1'b1, 1'b0);
        t_crossover(16'h0040);
        t_crossover(16'h0020);
        apply(16'h0000, 16'h0000);
        t_frame(3, 4, 1);
        t_frame(4, 4, 0);
        apply(16'h0002, 16'h0000);
        t_frame(3, 3, 0);
        // A second reset in mid-run must bring every register back to its reset value.
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values();
        give_verdict();
    end
endmodule

`default_nettype wire
